// ---- mtc_params.svh ----
// constants for the transmit configuration block
// assumes inclusion by name from mtc_decode and mtc_top
`ifndef MTC_PARAMS_SVH
`define MTC_PARAMS_SVH
`define MTC_ADDR_TXCFG 12'h040
`define MTC_ADDR_CTRL 12'h044
`define MTC_VER_HI_LSB 26
`define MTC_VER_LO_BIT 23
`define MTC_GAP_LOW_LSB 24
`define MTC_GAP_HIGH_BIT 19
`define MTC_LOOP_LSB 17
`define MTC_CRC_BIT 16
`define MTC_BURST_LSB 8
`define MTC_WR_MASK 32'h030F0700
`define MTC_GAP_MIN 8'h60
`define MTC_BURST_MIN 11'h010
`define MTC_GAP_MIN_NS 96
`endif

// ---- mtc_pkg.sv ----
// types for the transmit configuration block
// assumes mtc_params.svh is on the include path
package mtc_pkg;
    typedef enum logic [1:0] {
        MTC_LOOP_NORMAL = 2'h0,
        MTC_LOOP_MAC = 2'h1
    } mtc_loop_t;
    typedef struct packed {
        logic [7:0] gap_bits;
        logic gap_valid;
        logic mac_loop;
        logic loop_valid;
        logic append_fcs;
        logic [10:0] burst_bytes;
        logic burst_unlimited;
    } mtc_cfg_t;
endpackage : mtc_pkg

// ---- mtc_decode.sv ----
// decoder of gap and burst codes into bit times and bytes
// assumes codes come straight from the configuration register
`timescale 1ns/1ns
`default_nettype none
`include "mtc_params.svh"
module mtc_decode (
    input wire logic [2:0] gap_code,
    input wire logic [2:0] burst_code,
    output logic [7:0] gap_bits,
    output logic gap_valid,
    output logic [10:0] burst_bytes,
    output logic burst_unlimited
);
    always_comb begin
        gap_valid = 1'b1;
        case (gap_code)
            3'h3: gap_bits = `MTC_GAP_MIN; // [RL2]
            3'h5: gap_bits = `MTC_GAP_MIN + 8'h08; // [RL2]
            3'h7: gap_bits = `MTC_GAP_MIN + 8'h10; // [RL2]
            3'h1: gap_bits = `MTC_GAP_MIN + 8'h18; // [RL2]
            3'h2: gap_bits = `MTC_GAP_MIN + 8'h30; // [RL2]
            default: begin
                // reserved codes fall back to the minimum gap
                gap_bits = `MTC_GAP_MIN;
                gap_valid = 1'b0;
            end
        endcase
    end
    always_comb begin
        burst_unlimited = (burst_code == 3'h7); // [RL8]
        burst_bytes = `MTC_BURST_MIN << burst_code; // [RL8]
        if (burst_unlimited) begin
            burst_bytes = 11'h000;
        end
    end
endmodule : mtc_decode
`default_nettype wire

// ---- mtc_top.sv ----
// transmit configuration register with apb slave
// assumes apb master on CLOCK; mac datapath consumes CFG
// What this block does
// [RL1] gap lengthened from 96 up to 144 bits
// [RL2] three-bit gap code selects added bit times
// [RL3] loopback field: 00 normal, 01 mac loopback
// [RL4] mac loopback keeps frames off the media
// [RL5] loopback ignores link status entirely
// [RL6] software forces phy loopback for analog tests; this block has no phy loopback control
// [RL7] crc bit set means no fcs appended
// [RL8] burst code limits tx dma burst bytes
// [RL9] software writes only after transmitter enabled; writes land here regardless of enable
// [RL10] read-only silicon version in bits 30-26, 23
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "mtc_params.svh"
module mtc_top (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TX_FRAME_VALID,
    output logic MEDIA_TX_VALID,
    output logic LOOP_RX_VALID,
    output logic TRANSMITTER_ENABLE,
    output mtc_pkg::mtc_cfg_t CFG
);
    import mtc_pkg::*;
    // arbitrary silicon code, not any real variant
    parameter logic [4:0] SILICON_VERSION_UPPER = 5'h15;
    parameter logic SILICON_VERSION_LOWER = 1'b1;

    logic [31:0] txcfg_q, txcfg_d;
    logic te_q, te_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic [31:0] wmask;
    logic [31:0] read_word;
    logic access, hit_cfg, hit_ctrl;
    logic [2:0] gap_code;
    logic mac_loop;
    mtc_cfg_t cfg_d;

    assign access = PSEL && PENABLE;
    assign hit_cfg = (PADDR == `MTC_ADDR_TXCFG);
    assign hit_ctrl = (PADDR == `MTC_ADDR_CTRL);

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_lane
            assign wmask[i*8 +: 8] = {8{PSTRB[i]}};
        end
    endgenerate

    always_comb begin
        read_word = 32'h00000000;
        if (hit_cfg) begin
            read_word = txcfg_q & `MTC_WR_MASK;
            read_word[`MTC_VER_HI_LSB +: 5] = SILICON_VERSION_UPPER; // [RL10]
            read_word[`MTC_VER_LO_BIT] = SILICON_VERSION_LOWER; // [RL10]
        end else if (hit_ctrl) begin
            read_word[0] = te_q;
        end
    end

    always_comb begin
        txcfg_d = txcfg_q;
        te_d = te_q;
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (PSEL && !PENABLE) begin
            err_d = !(hit_cfg || hit_ctrl);
            rdata_d = read_word;
        end
        if (access && PWRITE && hit_cfg) begin
            // writes land regardless of enable; driver must order them
            txcfg_d = (txcfg_q & ~(wmask & `MTC_WR_MASK)) |
                      (PWDATA & wmask & `MTC_WR_MASK); // [RL9]
        end
        if (access && PWRITE && hit_ctrl && PSTRB[0]) begin
            te_d = PWDATA[0];
        end
        if (access) begin
            err_d = err_q;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            txcfg_q <= 32'h00000000;
            te_q <= 1'b0;
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else begin
            txcfg_q <= txcfg_d;
            te_q <= te_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // no wait states: setup cycle latches the read word
    assign PREADY = 1'b1;
    assign PRDATA = rdata_q;
    assign PSLVERR = access && err_q;
    assign TRANSMITTER_ENABLE = te_q;

    assign gap_code = {txcfg_q[`MTC_GAP_HIGH_BIT],
                       txcfg_q[`MTC_GAP_LOW_LSB +: 2]}; // [RL2]
    // reserved loopback codes behave as normal operation
    assign mac_loop = (txcfg_q[`MTC_LOOP_LSB +: 2] == MTC_LOOP_MAC); // [RL3]

    mtc_decode u_decode (
        .gap_code(gap_code),
        .burst_code(txcfg_q[`MTC_BURST_LSB +: 3]),
        .gap_bits(cfg_d.gap_bits),
        .gap_valid(cfg_d.gap_valid),
        .burst_bytes(cfg_d.burst_bytes),
        .burst_unlimited(cfg_d.burst_unlimited)
    );

    // plain assigns: decoder ports drive the other fields
    assign cfg_d.mac_loop = mac_loop; // [RL3]
    assign cfg_d.loop_valid = !txcfg_q[`MTC_LOOP_LSB + 1]; // [RL3]
    assign cfg_d.append_fcs = !txcfg_q[`MTC_CRC_BIT]; // [RL7]
    // gap scales with bit time at every speed
    assign CFG = cfg_d; // [RL1]

    // frames steer to loopback, no link gating on either path
    assign MEDIA_TX_VALID = TX_FRAME_VALID && !mac_loop; // [RL4] [RL5]
    assign LOOP_RX_VALID = TX_FRAME_VALID && mac_loop; // [RL5]
endmodule : mtc_top
`default_nettype wire

// ---- mtc_chk.sv ----
// assertions on the transmit configuration ports
// assumes binding onto mtc_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module mtc_chk (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic TX_FRAME_VALID,
    input wire logic MEDIA_TX_VALID,
    input wire logic LOOP_RX_VALID,
    input wire mtc_pkg::mtc_cfg_t CFG
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    sequence s_acc; PSEL && PENABLE && PADDR == 12'h040; endsequence
    sequence s_wr; s_acc ##0 PWRITE && PSTRB[3:2] == 2'h3; endsequence
    property p_rg; CFG.gap_valid |-> CFG.gap_bits inside
        {8'h60, 8'h68, 8'h70, 8'h78, 8'h90}; endproperty
    property p_g3; s_wr ##0 PWDATA[25:24] == 2'h3 && !PWDATA[19]
        |=> CFG.gap_bits == 8'h60 && CFG.gap_valid; endproperty
    property p_lb; s_wr ##0 PWDATA[18:17] == 2'h1 |=> CFG.mac_loop;
    endproperty
    property p_md;
        MEDIA_TX_VALID == (TX_FRAME_VALID && !CFG.mac_loop); endproperty
    property p_lr;
        LOOP_RX_VALID == (TX_FRAME_VALID && CFG.mac_loop); endproperty
    property p_fc; s_wr |=> CFG.append_fcs == !$past(PWDATA[16]);
    endproperty
    property p_bu; !CFG.burst_unlimited |-> $onehot(CFG.burst_bytes[10:4])
        && CFG.burst_bytes[3:0] == 4'h0; endproperty
    property p_rv; s_acc ##0 !PWRITE |-> !PRDATA[31]
        && PRDATA[22:20] == 3'h0 && PRDATA[15:11] == 5'h00
        && PRDATA[7:0] == 8'h00; endproperty
    a_rg: assert property (p_rg) else $error("gap range");
    a_g3: assert property (p_g3) else $error("gap code");
    a_lb: assert property (p_lb) else $error("loop select");
    a_md: assert property (p_md) else $error("media valid");
    a_lr: assert property (p_lr) else $error("loop valid");
    a_fc: assert property (p_fc) else $error("fcs append");
    a_bu: assert property (p_bu) else $error("burst size");
    a_rv: assert property (p_rv) else $error("reserved bits");
endmodule : mtc_chk
bind mtc_top mtc_chk chk_u (.*);
`default_nettype wire

// ---- mtc_phy.sv ----
// phy model counting frames that reach the media wires
// assumes one frame per cycle of media valid
`timescale 1ns/1ns
`default_nettype none
module mtc_phy (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic phy_loop,
    input wire logic tx_valid,
    output logic [7:0] wire_cnt
);
    // phy loopback keeps frames off the line
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) wire_cnt <= 8'h00;
        else if (tx_valid && !phy_loop) wire_cnt <= wire_cnt + 8'h01;
    end
endmodule : mtc_phy
`default_nettype wire

// ---- test_mac_transmit_configuration.sv ----
// self-checking bench for the transmit configuration block
// assumes mtc_top, mtc_phy and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
    mismatches++; $display("wrong value at %0t: %h", $time, a); end end
module test_mac_transmit_configuration;
    import mtc_pkg::*;
    logic CLOCK = '0, RESETN = '0, PSEL = '0, PENABLE = '0, PWRITE = '0;
    logic TX_FRAME_VALID = '0, PREADY, PSLVERR, MEDIA_TX_VALID, er;
    logic LOOP_RX_VALID, TRANSMITTER_ENABLE;
    logic [11:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic [3:0] PSTRB = 4'hF;
    logic [7:0] wire_cnt;
    mtc_cfg_t CFG;
    int mismatches = 0, comparisons = 0;
    logic [31:0] wd [8] = '{32'h03000000, 32'h010B0100, 32'h030C0200,
        32'h01060300, 32'h02000400, 32'h00000500, 32'h00080600, 32'hFE88FFFF};
    logic [23:0] cf [8] = '{24'h60B020, 24'h68E040, 24'h709080, 24'h789100,
        24'h90B200, 24'h603400, 24'h603800, 24'h603001};
    mtc_top dut_u (.*);
    mtc_phy phy_u (.CLOCK(CLOCK), .RESETN(RESETN), .phy_loop(1'h0),
        .tx_valid(MEDIA_TX_VALID), .wire_cnt(wire_cnt));
    always #50 CLOCK = ~CLOCK;
    task end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'h1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'h1 && n < 16);
        if (n == 16) begin
            mismatches++;
            end_of_test;
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge CLOCK);
    endtask : apb
    initial begin
        repeat (8) @(posedge CLOCK);
        RESETN <= 1'h1;
        `CHK(CFG, 24'h603020)
        apb(1'h0, 12'h040, '0);
        `CHK(rd, 32'h54800000)
        `CHK(PREADY, 1'h1)
        apb(1'h1, 12'h044, 32'h1);
        `CHK(TRANSMITTER_ENABLE, 1'h1)
        for (int i = 0; i < 8; i++) begin
            apb(1'h1, 12'h040, wd[i]);
            `CHK(CFG, cf[i])
            apb(1'h0, 12'h040, '0);
            `CHK(rd, wd[i] & 32'h030F0700 | 32'h54800000)
            TX_FRAME_VALID <= 1'h1;
            @(posedge CLOCK);
            `CHK(MEDIA_TX_VALID, !cf[i][14])
            `CHK(LOOP_RX_VALID, cf[i][14])
            TX_FRAME_VALID <= 1'h0;
        end
        apb(1'h0, 12'h048, '0);
        `CHK({er, rd}, {1'h1, 32'h0})
        `CHK(wire_cnt, 8'h07)
        // mid-run reset must restore defaults
        apb(1'h1, 12'h040, wd[1]);
        RESETN <= 1'h0;
        @(posedge CLOCK);
        RESETN <= 1'h1;
        @(posedge CLOCK);
        `CHK(CFG, 24'h603020)
        `CHK(TRANSMITTER_ENABLE, 1'h0)
        end_of_test;
    end
endmodule : test_mac_transmit_configuration
`default_nettype wire
